// [design/eihw_map.vh]
// Functional notes
// (R1) Six requests are taken: falls of lines a, b and c, the rise of b, two timers.
// (R2) Line b feeds request zero on its fall and request three on its rise.
// (R3) A request is arbitrated only when its own and the global enable are set.
// (R4) The winner among enabled pending requests follows the priority register.
// (R5) Request n owns vector bytes 2n and 2n+1 of program memory.
// (R6) A grant clears the global enable until software sets it again.
// (R7) On a grant the core saves its state and is sent to the request's vector.
// (R8) The vector byte and the next byte form a 16-bit address loaded into the PC.
// (R9) Pending requests stay readable in the request register even when masked.
// (R10) Each of the three port lines can be set as digital or analog input.
// (R11) The port lines also feed the counter/timers as the timer input; the code feeds only line a to external_timer_input.
// (R12) The halt instruction gates off the CPU clock; the oscillator runs on.
// (R13) In halt the timers and edge detection of requests zero to three run on.
// (R14) Halt ends only when an enabled request is actually granted.
// (R15) After the wake service routine, code resumes after the halt instruction.
// (R16) A request bit is set by its event, cleared on grant, writable by software.
`ifndef EIHW_MAP_VH
`define EIHW_MAP_VH

`define EIHW_OFF_REQ    8'h00
`define EIHW_OFF_MASK   8'h04
`define EIHW_OFF_PRIO   8'h08
`define EIHW_OFF_PCFG   8'h0C
`define EIHW_OFF_STAT   8'h10
`define EIHW_OFF_IST    8'h14
`define EIHW_OFF_IMSK   8'h18

`define EIHW_NREQ       6
`define EIHW_NLINE      3
`define EIHW_MASK_W     8
`define EIHW_MASK_GLB   7
`define EIHW_PRIO_W     3
`define EIHW_IST_W      3
`define EIHW_IST_GRANT  0
`define EIHW_IST_WAKE   1
`define EIHW_IST_OVR    2
`define EIHW_VEC_W      16

`define EIHW_RST_REQ    6'h00
`define EIHW_RST_MASK   8'h00
`define EIHW_RST_PRIO   3'h0
`define EIHW_RST_PCFG   3'h0
`define EIHW_RST_IST    3'h0
`define EIHW_RST_VEC    16'h0000

`define EIHW_LINE_A     0
`define EIHW_LINE_B     1
`define EIHW_LINE_C     2

`endif

// [design/eihw_edge_detect.v]
`default_nettype none

// ----------------------------------------------------------------------
// Edge detector for the port lines
// ----------------------------------------------------------------------
// The first sample after reset only primes the history, so a line that
// is already low or high at release raises no false edge.
module eihw_edge_detect
#(
	parameter W = 3
)
(
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] line_in,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);
	reg [W-1:0] prev;
	reg         primed;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev   <= {W{1'b0}};
			primed <= 1'b0;
		end
		else
		begin
			prev   <= line_in;
			primed <= 1'b1;
		end
	end

	assign rise = {W{primed}} & line_in & ~prev;
	assign fall = {W{primed}} & ~line_in & prev;
endmodule // eihw_edge_detect

`default_nettype wire

// [design/eihw_prio_enc.v]
`default_nettype none
`include "eihw_map.vh"

// ----------------------------------------------------------------------
// Rotating priority encoder
// ----------------------------------------------------------------------
// The request named by top wins first, then the following numbers in
// turn, wrapping after request five. A top above five acts as zero.
module eihw_prio_enc
(
	input  wire [`EIHW_NREQ-1:0]   pend,
	input  wire [`EIHW_PRIO_W-1:0] top,
	output reg                     valid,
	output reg  [2:0]              idx
);
	function [2:0] wrap_add;
		input [2:0] a;
		input [2:0] b;
		reg   [3:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			if (s >= 4'd6)
				s = s - 4'd6;
			wrap_add = s[2:0];
		end
	endfunction

	reg [2:0] base;
	reg [2:0] cand;
	integer   k;

	always @*
	begin
		base  = (top > 3'd5) ? 3'd0 : top;
		valid = 1'b0;
		idx   = 3'd0;
		cand  = 3'd0;
		for (k = 5; k >= 0; k = k - 1)
		begin
			cand = wrap_add(base, k[2:0]);
			if (pend[cand])
			begin
				valid = 1'b1;
				idx   = cand;
			end
		end
	end
endmodule // eihw_prio_enc

`default_nettype wire

// [design/eihw_top.v]
`default_nettype none
`include "eihw_map.vh"

module eihw_top
(
	input  wire                    pclk,
	input  wire                    presetn,
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [7:0]              paddr,
	input  wire [31:0]             pwdata,
	output reg  [31:0]             prdata,
	output wire                    pready,
	output wire                    pslverr,
	input  wire                    port_in_line_a,
	input  wire                    port_in_line_b,
	input  wire                    port_in_line_c,
	input  wire [`EIHW_NLINE-1:0]  comparator_result,
	output wire [`EIHW_NLINE-1:0]  analog_select,
	output wire                    external_timer_input,
	input  wire                    timer_zero_event,
	input  wire                    timer_one_event,
	input  wire                    core_halt_exec,
	input  wire                    core_int_ack,
	output wire                    core_int_req,
	output wire                    cpu_clk_en,
	output wire                    ctx_save,
	output wire                    pm_rd,
	output reg  [`EIHW_VEC_W-1:0]  pm_addr,
	input  wire [7:0]              pm_data,
	output wire                    pc_load,
	output reg  [`EIHW_VEC_W-1:0]  pc_value,
	output wire                    host_irq
);
	// ------------------------------------------------------------------
	// Vector sequencer states
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b000;
	localparam [2:0] ST_SAVE = 3'b001;
	localparam [2:0] ST_HI   = 3'b010;
	localparam [2:0] ST_LO   = 3'b011;
	localparam [2:0] ST_LOAD = 3'b100;

	function [`EIHW_VEC_W-1:0] vec_addr;
		input [2:0] n;
		input       second;
		begin
			vec_addr = {12'h000, n, second};
		end
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [`EIHW_NREQ-1:0]   req;
	reg [`EIHW_MASK_W-1:0] mask;
	reg [`EIHW_PRIO_W-1:0] prio;
	reg [`EIHW_NLINE-1:0]  pcfg;
	reg [`EIHW_IST_W-1:0]  ist;
	reg [`EIHW_IST_W-1:0]  imsk;
	reg                    halted;
	reg [2:0]              state;
	reg [2:0]              gnt_idx;
	reg [7:0]              vec_hi;

	reg [`EIHW_NREQ-1:0]   next_req;
	reg [`EIHW_MASK_W-1:0] next_mask;
	reg [`EIHW_IST_W-1:0]  next_ist;
	reg [2:0]              next_state;
	reg                    next_halted;
	reg [31:0]             next_prdata;

	wire [`EIHW_NLINE-1:0] line_raw;
	wire [`EIHW_NLINE-1:0] line_sel;
	wire [`EIHW_NLINE-1:0] line_rise;
	wire [`EIHW_NLINE-1:0] line_fall;
	wire [`EIHW_NREQ-1:0]  req_event;
	wire [`EIHW_NREQ-1:0]  req_eff;
	wire                   win_valid;
	wire [2:0]             win_idx;
	wire                   grant;
	wire                   ev_overrun;

	// ------------------------------------------------------------------
	// Port lines and edge detection
	// ------------------------------------------------------------------
	assign line_raw = {port_in_line_c, port_in_line_b, port_in_line_a};
	assign line_sel = (pcfg & comparator_result)
		| (~pcfg & line_raw); // see (R10)
	assign analog_select = pcfg; // see (R10)
	assign external_timer_input = line_sel[`EIHW_LINE_A]; // see (R11)

	// Runs on pclk, which halt never gates.
	eihw_edge_detect #(.W(`EIHW_NLINE)) u_edge
	(
		.pclk    (pclk),
		.presetn (presetn),
		.line_in (line_sel),
		.rise    (line_rise),
		.fall    (line_fall)
	); // see (R13)

	assign req_event[0] = line_fall[`EIHW_LINE_B]; // see (R2)
	assign req_event[1] = line_fall[`EIHW_LINE_C]; // see (R1)
	assign req_event[2] = line_fall[`EIHW_LINE_A]; // see (R1)
	assign req_event[3] = line_rise[`EIHW_LINE_B]; // see (R2)
	assign req_event[4] = timer_zero_event; // see (R1)
	assign req_event[5] = timer_one_event; // see (R1)

	// ------------------------------------------------------------------
	// Masking and arbitration
	// ------------------------------------------------------------------
	assign req_eff = req & mask[`EIHW_NREQ-1:0]
		& {`EIHW_NREQ{mask[`EIHW_MASK_GLB]}}; // see (R3)

	eihw_prio_enc u_prio
	(
		.pend  (req_eff),
		.top   (prio),
		.valid (win_valid),
		.idx   (win_idx)
	); // see (R4)

	// A halted core cannot answer, so the request is granted at once.
	assign core_int_req = win_valid && (state == ST_IDLE) && !halted;
	assign grant = win_valid && (state == ST_IDLE)
		&& (core_int_ack || halted); // see (R14)

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	function is_mapped;
		input [7:0] a;
		begin
			case (a)
				`EIHW_OFF_REQ, `EIHW_OFF_MASK, `EIHW_OFF_PRIO,
				`EIHW_OFF_PCFG, `EIHW_OFF_STAT, `EIHW_OFF_IST,
				`EIHW_OFF_IMSK:
					is_mapped = 1'b1;
				default:
					is_mapped = 1'b0;
			endcase
		end
	endfunction

	wire acc    = psel && penable;
	wire wr     = acc && pwrite;
	wire mapped = is_mapped(paddr);

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	wire wr_req  = wr && (paddr == `EIHW_OFF_REQ);
	wire wr_mask = wr && (paddr == `EIHW_OFF_MASK);
	wire wr_ist  = wr && (paddr == `EIHW_OFF_IST);
	wire wr_prio = wr && (paddr == `EIHW_OFF_PRIO);
	wire wr_pcfg = wr && (paddr == `EIHW_OFF_PCFG);
	wire wr_imsk = wr && (paddr == `EIHW_OFF_IMSK);

	always @*
	begin
		case (paddr)
			`EIHW_OFF_REQ:  next_prdata = {26'h0, req}; // see (R9)
			`EIHW_OFF_MASK: next_prdata = {24'h0, mask};
			`EIHW_OFF_PRIO: next_prdata = {29'h0, prio};
			`EIHW_OFF_PCFG: next_prdata = {29'h0, pcfg};
			`EIHW_OFF_STAT: next_prdata = {24'h0, win_idx, win_valid,
				state, halted};
			`EIHW_OFF_IST:  next_prdata = {29'h0, ist};
			`EIHW_OFF_IMSK: next_prdata = {29'h0, imsk};
			default:        next_prdata = 32'h0000_0000;
		endcase
	end

	// Read data is taken in the setup cycle, so it stands for the whole
	// access cycle without a wait state.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= next_prdata;
	end

	// ------------------------------------------------------------------
	// Request, mask and event status update
	// ------------------------------------------------------------------
	// An event on a bit that is still set is lost, so it is flagged.
	assign ev_overrun = |(req_event & req);

	always @*
	begin
		next_req = req;
		if (wr_req)
			next_req = pwdata[`EIHW_NREQ-1:0]; // see (R16)
		if (grant)
			next_req[win_idx] = 1'b0; // see (R16)
		// Events are merged last, so a set beats a grant or a write of 0.
		next_req = next_req | req_event; // see (R16)

		next_mask = mask;
		if (wr_mask)
			next_mask = pwdata[`EIHW_MASK_W-1:0];
		if (grant)
			next_mask[`EIHW_MASK_GLB] = 1'b0; // see (R6)

		next_ist = ist;
		if (wr_ist)
			next_ist = ist & ~pwdata[`EIHW_IST_W-1:0];
		next_ist[`EIHW_IST_GRANT] = next_ist[`EIHW_IST_GRANT] | grant;
		next_ist[`EIHW_IST_WAKE] = next_ist[`EIHW_IST_WAKE]
			| (grant && halted);
		next_ist[`EIHW_IST_OVR] = next_ist[`EIHW_IST_OVR] | ev_overrun;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req  <= `EIHW_RST_REQ;
			mask <= `EIHW_RST_MASK;
			ist  <= `EIHW_RST_IST;
		end
		else
		begin
			req  <= next_req;
			mask <= next_mask;
			ist  <= next_ist;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prio <= `EIHW_RST_PRIO;
			pcfg <= `EIHW_RST_PCFG;
			imsk <= `EIHW_RST_IST;
		end
		else
		begin
			if (wr_prio)
				prio <= pwdata[`EIHW_PRIO_W-1:0]; // see (R4)
			if (wr_pcfg)
				pcfg <= pwdata[`EIHW_NLINE-1:0]; // see (R10)
			if (wr_imsk)
				imsk <= pwdata[`EIHW_IST_W-1:0];
		end
	end

	// Event flags reach the host line as soon as they are stored.
	assign host_irq = |(ist & imsk);

	// ------------------------------------------------------------------
	// Halt and wake
	// ------------------------------------------------------------------
	// Halt is left only at a grant, so the saved PC already points past
	// the halt instruction and the return resumes there.
	always @*
	begin
		next_halted = halted;
		// A halt while a vector is being fetched is ignored, since the
		// sequencer still needs the core to take the new PC.
		if (core_halt_exec && (state == ST_IDLE))
			next_halted = 1'b1; // see (R12)
		if (grant)
			next_halted = 1'b0; // see (R14) see (R15)
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			halted <= 1'b0;
		else
			halted <= next_halted;
	end

	assign cpu_clk_en = !halted; // see (R12)

	// ------------------------------------------------------------------
	// Vector sequencer
	// ------------------------------------------------------------------
	always @*
	begin
		case (state)
			ST_IDLE: next_state = grant ? ST_SAVE : ST_IDLE;
			ST_SAVE: next_state = ST_HI;
			ST_HI:   next_state = ST_LO;
			ST_LO:   next_state = ST_LOAD;
			ST_LOAD: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state    <= ST_IDLE;
			gnt_idx  <= 3'd0;
			vec_hi   <= 8'h00;
			pm_addr  <= `EIHW_RST_VEC;
			pc_value <= `EIHW_RST_VEC;
		end
		else
		begin
			state <= next_state;
			case (state)
				ST_IDLE:
				begin
					if (grant)
					begin
						gnt_idx <= win_idx;
						pm_addr <= vec_addr(win_idx, 1'b0); // see (R5)
					end
				end
				// The address runs one cycle ahead of the byte taken,
				// because program memory answers a cycle late.
				ST_SAVE:
				begin
					pm_addr <= vec_addr(gnt_idx, 1'b1); // see (R5)
				end
				ST_HI:
				begin
					vec_hi <= pm_data; // see (R8)
				end
				ST_LO:
				begin
					pc_value <= {vec_hi, pm_data}; // see (R8)
				end
				default:
				begin
				end
			endcase
		end
	end

	// The core stores PC and flags in ST_SAVE, the first of the two vector read cycles.
	assign ctx_save = (state == ST_SAVE); // see (R7)
	assign pm_rd    = (state == ST_SAVE) || (state == ST_HI);
	assign pc_load  = (state == ST_LOAD); // see (R7) see (R8)
endmodule // eihw_top

`default_nettype wire

// [verif/eihw_assertions.sv]
`default_nettype none
// ------------------------------------------------------------
// Sequencer timing and bus error checks
// ------------------------------------------------------------
module eihw_assertions
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pslverr,
	input wire logic        core_halt_exec,
	input wire logic        core_int_ack,
	input wire logic        core_int_req,
	input wire logic        cpu_clk_en,
	input wire logic        ctx_save,
	input wire logic        pm_rd,
	input wire logic [15:0] pm_addr,
	input wire logic [7:0]  pm_data,
	input wire logic        pc_load,
	input wire logic [15:0] pc_value,
	input wire logic        host_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_save_load: assert property (ctx_save |-> ##3 pc_load)
		else $error("load not three cycles after save");
	a_save_read: assert property (
		ctx_save |-> pm_rd ##1 pm_rd ##1 !pm_rd)
		else $error("vector read not two cycles");
	a_vec_addr: assert property (
		ctx_save |-> (!pm_addr[0] && pm_addr < 16'hC)
		##1 (pm_addr == $past(pm_addr) + 16'h1))
		else $error("bad vector address");
	a_pc_bytes: assert property (
		pc_load |-> pc_value == {$past(pm_data, 2), $past(pm_data)})
		else $error("bad pc value");
	a_halt_cause: assert property (
		$fell(cpu_clk_en) |-> $past(core_halt_exec))
		else $error("clock gated without halt");
	a_wake_grant: assert property (
		$rose(cpu_clk_en) |-> ctx_save)
		else $error("wake without grant");
	a_ack_grant: assert property (
		core_int_req && core_int_ack |=> ctx_save)
		else $error("accepted request not granted");
	a_grant_space: assert property (
		ctx_save |=> !ctx_save [*4])
		else $error("grants too close");
	a_halt_noreq: assert property (
		!cpu_clk_en |-> !core_int_req)
		else $error("request while halted");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	c_grant: cover property (core_int_req && core_int_ack);
	c_wake: cover property ($rose(cpu_clk_en));
	c_err: cover property (pslverr);
	c_irq: cover property (host_irq);
endmodule // eihw_assertions

bind eihw_top eihw_assertions eihw_assertions_i (.pclk, .presetn, .psel,
	.penable, .pslverr, .core_halt_exec, .core_int_ack, .core_int_req,
	.cpu_clk_en, .ctx_save, .pm_rd, .pm_addr, .pm_data, .pc_load, .pc_value,
	.host_irq);
`default_nettype wire

// [verif/eihw_core_model.sv]
`default_nettype none
// ------------------------------------------------------------
// Core sequencer and program memory
// ------------------------------------------------------------
module eihw_core_model
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        core_int_req,
	input  wire logic        pm_rd,
	input  wire logic [15:0] pm_addr,
	output var  logic        core_int_ack,
	output var  logic [7:0]  pm_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	int lim;
	// Acceptance waits 0 to 3 cycles; data flips when not read.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_int_ack <= 1'b0;
			cnt <= 0;
			lim <= 0;
			pm_data <= 8'hA5;
		end
		else
		begin
			core_int_ack <= core_int_req && cnt >= lim;
			cnt <= core_int_req ? cnt + 1 : 0;
			lim <= core_int_req ? lim : $urandom_range(3);
			pm_data <= pm_rd ? {pm_addr[3:0] ^ 4'hA, ~pm_addr[3:0]} : ~pm_data;
		end
	end
endmodule // eihw_core_model
`default_nettype wire

// [verif/test_edge_interrupt_halt_wake.sv]
`default_nettype none
module test_edge_interrupt_halt_wake;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        port_in_line_a, port_in_line_b, port_in_line_c;
	logic        timer_zero_event, timer_one_event, core_halt_exec;
	logic        core_int_ack, core_int_req, cpu_clk_en, ctx_save, pm_rd;
	logic        pc_load, host_irq, external_timer_input;
	logic [2:0]  comparator_result, analog_select;
	logic [7:0]  paddr, pm_data;
	logic [15:0] pm_addr, pc_value;
	logic [31:0] pwdata, prdata;
	logic [5:0]  p, m;
	logic [32:0] rq[$];
	logic [15:0] vq[$];
	int          n_fail, tests_run, cyc, i, j, t, w;

	eihw_top eihw_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port_in_line_a, .port_in_line_b,
		.port_in_line_c, .comparator_result, .analog_select,
		.external_timer_input, .timer_zero_event, .timer_one_event,
		.core_halt_exec, .core_int_ack, .core_int_req, .cpu_clk_en, .ctx_save,
		.pm_rd, .pm_addr, .pm_data, .pc_load, .pc_value, .host_irq);
	eihw_core_model eihw_core_model_i (.pclk, .presetn, .core_int_req,
		.pm_rd, .pm_addr, .core_int_ack, .pm_data);

	always #4 pclk = ~pclk;

	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A read notes {error, data} as its expected answer.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic e = 1'b0);
		if (!wr)
			rq.push_back({e, d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic ev(input int k);
		case (k)
			0: port_in_line_b <= 1'b0;
			1: port_in_line_c <= 1'b0;
			2: port_in_line_a <= 1'b0;
			3: port_in_line_b <= 1'b1;
			4: timer_zero_event <= 1'b1;
			default: timer_one_event <= 1'b1;
		endcase
		@(posedge pclk);
		timer_zero_event <= 1'b0;
		timer_one_event <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wpc();
		for (int c = 0; c < 40 && pc_load !== 1'b1; c++)
			@(posedge pclk);
		@(posedge pclk);
	endtask

	function automatic int win(input logic [5:0] q, input int s);
		s = s > 5 ? 0 : s;
		for (int k = 0; k < 6; k++)
			if (q[(s + k) % 6])
				return (s + k) % 6;
		return 0;
	endfunction

	function automatic logic [15:0] vec(input int n);
		return {4'(2 * n) ^ 4'hA, ~4'(2 * n),
			4'(2 * n + 1) ^ 4'hA, ~4'(2 * n + 1)};
	endfunction

	always @(posedge pclk)
	begin
		cyc++;
		if (psel && penable && !pwrite)
			chk({pslverr, prdata}, rq.pop_front());
		if (pc_load === 1'b1)
			chk(pc_value, vq.pop_front());
		if (cyc == 5000)
		begin
			n_fail++;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(32'h946C6232));
		pclk = 1'b0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{timer_zero_event, timer_one_event, core_halt_exec} = '0;
		{port_in_line_a, port_in_line_b, port_in_line_c} = 3'h7;
		comparator_result = 3'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 8; i++)
			apb(0, 8'(i * 4), 0, i == 7);
		for (i = 0; i < 6; i++)
		begin
			ev(i);
			apb(0, 8'h00, (1 << (i + 1)) - 1);
		end
		apb(1, 8'h00, 0);
		apb(0, 8'h00, 0);
		for (i = 0; i < 8; i++)
		begin
			j = $urandom_range(5);
			p = 6'($urandom) | (6'h1 << j);
			m = 6'($urandom) | (6'h1 << j);
			t = $urandom_range(7);
			w = win(p & m, t);
			apb(1, 8'h00, {26'h0, p});
			apb(1, 8'h08, t);
			vq.push_back(vec(w));
			apb(1, 8'h04, {24'h0, 2'h2, m});
			wpc();
			apb(0, 8'h04, {26'h0, m});
			apb(0, 8'h00, {26'h0, p & ~(6'h1 << w)});
		end
		apb(1, 8'h00, 0);
		port_in_line_c <= 1'b1;
		apb(1, 8'h04, 32'h82);
		core_halt_exec <= 1'b1;
		@(posedge pclk);
		core_halt_exec <= 1'b0;
		@(posedge pclk);
		chk(cpu_clk_en, 0);
		ev(4);
		apb(0, 8'h00, 32'h10);
		chk(cpu_clk_en, 0);
		vq.push_back(vec(1));
		ev(1);
		wpc();
		chk(cpu_clk_en, 1);
		apb(0, 8'h00, 32'h10);
		ev(4);
		apb(0, 8'h14, 7);
		apb(1, 8'h18, 2);
		chk(host_irq, 1);
		apb(1, 8'h14, 2);
		chk(host_irq, 0);
		apb(0, 8'h14, 5);
		chk(analog_select, 0);
		chk(external_timer_input, 0);
		apb(1, 8'h0C, 7);
		chk(analog_select, 7);
		comparator_result <= 3'h5;
		@(posedge pclk);
		@(posedge pclk);
		chk(external_timer_input, 1);
		chk(vq.size(), 0);
		conclude();
	end
endmodule // test_edge_interrupt_halt_wake
`default_nettype wire
